// file: tsi_defines.svh
// Constants for the touch sensor serial slave, cascade and start-up logic.
// Notes on behaviour
// - Main-domain power-on resets every register, regulator-off bit cleared, so regulator runs.
// - Regulated-domain reset stays asserted until that supply is reported good.
// - Each channel independently runs fast start, then fine steps, then enables counters.
// - Registers and serial interface keep working while the regulated domain is off.
// - Data line is only pulled low or released; the pull-up makes the high.
// - Data may only change while the clock is low; changes at clock high are conditions.
// - Data falling at clock high is start, rising is stop; idle bus is high.
// - Eight-bit bytes, each followed by an acknowledge clock, any number per transfer.
// - An addressed receiver holds data low through the whole acknowledge clock high.
// - Master leaves the last read byte unacknowledged; device then releases the data line.
// - Slave address is fixed 010000 followed by the address select pin level.
// - Address byte bit 0 gives direction: 0 master writes, 1 master reads.
// - A write is start, address, command, data, each acknowledged, then stop.
// - A repeated start instead of stop begins a fresh transfer.
// - A read with no preceding command returns the sensor state byte first.
// - Without a stop, the sensor state byte is resent for every further byte.
// - Cascade direct read: primary byte first, then secondary, alternating until stop.
// - Alternating read addresses the primary; the secondary answers that address only then.
// - Primary outputs and samples on rising clock; secondary samples on falling input clock.
// - Secondary interrupt output is own interrupt ORed with the primary's interrupt.
// - In cascade only the secondary signals over the bus; primary keeps its interrupt pin.
// - Reading the sensor byte or a clear command clears the pending interrupt.
// - Secondary stops its internal clock generator and runs from the clock input.
`ifndef TSI_DEFINES_SVH
`define TSI_DEFINES_SVH
`define TSI_NCH 8
`define TSI_ADDR_FIXED 6'h10
`define TSI_BIDX_CMD 2'h1
`define TSI_BIDX_DATA 2'h2
`define TSI_BIT_LAST 4'h8
`define TSI_TX_LAST 4'h7
`define TSI_IDLE_BYTE 8'hFF
`define TSI_SDIV_DEF 16
`define TSI_REG_OFF_RST 1'b0
`define TSI_FAST_RST 8'hFF
`endif

// file: tsi_pkg.sv
// Types shared by the touch sensor serial slave and start-up logic.
`include "tsi_defines.svh"
package tsi_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX = 3'h1,
    S_ACK = 3'h2,
    S_TX = 3'h3,
    S_MACK = 3'h4,
    S_WAIT = 3'h5
  } tsi_i2c_e;

  typedef enum logic [1:0] {
    CH_FAST = 2'h0,
    CH_FINE = 2'h1,
    CH_RUN = 2'h2
  } tsi_chst_e;

  typedef struct packed {
    logic [`TSI_NCH-1:0] fast_start;
    logic [`TSI_NCH-1:0] fine_step;
    logic [`TSI_NCH-1:0] counters_en;
  } tsi_chan_s;

  typedef struct packed {
    logic [`TSI_NCH-1:0] nt_s1;
    logic [`TSI_NCH-1:0] nt_s2;
    logic [`TSI_NCH-1:0] fd_s1;
    logic [`TSI_NCH-1:0] fd_s2;
    tsi_chst_e [`TSI_NCH-1:0] st;
    tsi_chan_s o;
  } tsi_su_s;
endpackage

// file: tsi_startup.sv
// Per-channel fast start-up sequencer in the regulated domain.
`timescale 1ns/100ps
`default_nettype none
`include "tsi_defines.svh"
module tsi_startup (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic chan_rst_n,
  input wire logic [`TSI_NCH-1:0] chan_enable,
  input wire logic [`TSI_NCH-1:0] near_target,
  input wire logic [`TSI_NCH-1:0] fine_done,
  output tsi_pkg::tsi_chan_s chan
);
  import tsi_pkg::*;

  localparam tsi_su_s SU_RST = '{
    nt_s1: '0, nt_s2: '0, fd_s1: '0, fd_s2: '0,
    st: '{default: CH_FAST},
    o: '{fast_start: `TSI_FAST_RST, fine_step: '0, counters_en: '0}
  };

  tsi_su_s q;
  tsi_su_s d;
  tsi_chst_e [`TSI_NCH-1:0] nst;

  genvar g;
  generate
    for (g = 0; g < `TSI_NCH; g++) begin : g_ch
      always_comb begin
        case (q.st[g])
          CH_FAST: nst[g] = q.nt_s2[g] ? CH_FINE : CH_FAST;
          CH_FINE: nst[g] = q.fd_s2[g] ? CH_RUN : CH_FINE;
          CH_RUN: nst[g] = CH_RUN;
          default: nst[g] = CH_FAST;
        endcase
        // A disabled channel falls back so that re-enabling repeats fast start.
        if (!chan_enable[g]) begin
          nst[g] = CH_FAST;
        end
      end
    end
  endgenerate

  always_comb begin
    d = q;
    d.nt_s1 = near_target;
    d.nt_s2 = q.nt_s1;
    d.fd_s1 = fine_done;
    d.fd_s2 = q.fd_s1;
    d.st = nst;
    for (int i = 0; i < `TSI_NCH; i++) begin
      d.o.fast_start[i] = (nst[i] == CH_FAST) && chan_enable[i];
      d.o.fine_step[i] = (nst[i] == CH_FINE);
      d.o.counters_en[i] = (nst[i] == CH_RUN);
    end
  end

  // The regulated-domain reset is a plain synchronous level from the core.
  always_ff @(posedge core_clk) begin
    if (!resetn || !chan_rst_n) begin
      q <= SU_RST;
    end else begin
      q <= d;
    end
  end

  assign chan = q.o;

  chk_fast_first: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $rose(chan_rst_n) |-> (q.o.fast_start == `TSI_FAST_RST && q.o.counters_en == '0))
    else $error("channels did not begin in fast start");

  chk_run_after_fine: assert property (
    @(posedge core_clk) disable iff (!resetn || !chan_rst_n)
    ((q.o.counters_en & ~$past(q.o.counters_en) & ~$past(q.o.fine_step)) == '0))
    else $error("counters enabled without fine step phase");
endmodule
`default_nettype wire

// file: tsi_core.sv
// Serial slave, cascade sampling clock, interrupt chain and power control of the sensor.
`timescale 1ns/100ps
`default_nettype none
`include "tsi_defines.svh"
module tsi_core #(
  parameter int SAMPLE_DIV = `TSI_SDIV_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic address_select_pin,
  input wire logic clk_in,
  output logic clk_out,
  output logic sample_tick,
  input wire logic int_in_n,
  output logic int_out_n,
  input wire logic primary_mode,
  input wire logic secondary_mode,
  input wire logic cascade_en,
  input wire logic regulator_off_wr,
  input wire logic regulator_off_wdata,
  output logic regulator_off_bit,
  input wire logic intreg_supply_ok,
  output logic intreg_por_n,
  input wire logic own_int_event,
  input wire logic clear_int_cmd,
  input wire logic [7:0] sensor_state_byte,
  input wire logic [7:0] reply_byte,
  output logic [7:0] rx_byte,
  output logic rx_cmd_valid,
  output logic rx_data_valid,
  output logic sensor_read,
  input wire logic [`TSI_NCH-1:0] chan_enable,
  input wire logic [`TSI_NCH-1:0] near_target,
  input wire logic [`TSI_NCH-1:0] fine_done,
  output tsi_pkg::tsi_chan_s chan
);
  import tsi_pkg::*;

  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic a0_s1, a0_s2;
    logic ck_s1, ck_s2, ck_s3;
    logic ii_s1, ii_s2;
    logic sup_s1, sup_s2;
    tsi_i2c_e st;
    logic [3:0] cnt;
    logic [1:0] bidx;
    logic [7:0] sh;
    logic rw, ack, turn, alt, nack, cmd_seen, oe_n, sda_o;
    logic [7:0] rx_byte;
    logic cmd_vld, dat_vld, sensor_state_byte_rd;
    logic pend, int_n, reg_off, por_n;
    logic [15:0] div;
    logic ck_int, ck_pin, tick;
  } tsi_core_s;

  localparam tsi_core_s CORE_RST = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
    ii_s1: 1'b1, ii_s2: 1'b1,
    st: S_IDLE, oe_n: 1'b1, int_n: 1'b1,
    reg_off: `TSI_REG_OFF_RST, por_n: 1'b0,
    default: '0
  };

  tsi_core_s q;
  tsi_core_s d;
  logic rise, fall, start_det, stop_det, own_match, alt_match, sensor_state_byte_ld, nt;
  logic [7:0] ld_byte;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Only the second and third sync stages are looked at by any logic.
  assign rise = q.scl_s2 && !q.scl_s3;
  assign fall = !q.scl_s2 && q.scl_s3;
  assign start_det = q.scl_s2 && q.scl_s3 && !q.sda_s2 && q.sda_s3;
  assign stop_det = q.scl_s2 && q.scl_s3 && q.sda_s2 && !q.sda_s3;
  assign own_match = (q.sh[7:1] == {`TSI_ADDR_FIXED, q.a0_s2});
  // The secondary shares the primary address only for a direct read in cascade.
  assign alt_match = secondary_mode && cascade_en && q.sh[0] && !q.cmd_seen
                     && (q.sh[7:1] == {`TSI_ADDR_FIXED, 1'b0});

  always_comb begin
    d = q;
    sensor_state_byte_ld = 1'b0;
    nt = q.turn;
    ld_byte = `TSI_IDLE_BYTE;
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.a0_s1 = address_select_pin;
    d.a0_s2 = q.a0_s1;
    d.ck_s1 = clk_in;
    d.ck_s2 = q.ck_s1;
    d.ck_s3 = q.ck_s2;
    d.ii_s1 = int_in_n;
    d.ii_s2 = q.ii_s1;
    d.sup_s1 = intreg_supply_ok;
    d.sup_s2 = q.sup_s1;
    d.cmd_vld = 1'b0;
    d.dat_vld = 1'b0;
    d.tick = 1'b0;
    d.sda_o = 1'b0;

    // Power control lives on the main supply, so it ignores the regulated reset.
    if (regulator_off_wr) begin
      d.reg_off = regulator_off_wdata;
    end
    d.por_n = q.sup_s2;

    // Serial slave.
    case (q.st)
      S_IDLE, S_WAIT: begin
      end
      S_RX: begin
        if (rise) begin
          d.sh = {q.sh[6:0], q.sda_s2};
          d.cnt = q.cnt + 4'h1;
        end else if (fall && q.cnt == `TSI_BIT_LAST) begin
          d.st = S_ACK;
          d.ack = 1'b1;
          if (q.bidx == 2'h0) begin
            d.turn = 1'b1;
            d.rw = q.sh[0];
            d.alt = cascade_en && primary_mode && q.sh[0] && !q.cmd_seen;
            if (!own_match) begin
              if (alt_match) begin
                d.ack = 1'b0;
                d.rw = 1'b1;
                d.alt = 1'b1;
                d.turn = 1'b0;
              end else begin
                d.st = S_WAIT;
                d.ack = 1'b0;
              end
            end
          end else if (q.bidx == `TSI_BIDX_CMD) begin
            d.rx_byte = q.sh;
            d.cmd_vld = 1'b1;
            d.cmd_seen = 1'b1;
          end else begin
            d.rx_byte = q.sh;
            d.dat_vld = 1'b1;
          end
        end
      end
      S_ACK: begin
        if (fall) begin
          d.cnt = 4'h0;
          if (q.rw) begin
            d.st = S_TX;
            nt = q.turn;
            ld_byte = q.cmd_seen ? reply_byte : sensor_state_byte;
            sensor_state_byte_ld = nt && !q.cmd_seen;
            d.sh = nt ? ld_byte : `TSI_IDLE_BYTE;
          end else begin
            d.st = S_RX;
            if (q.bidx != `TSI_BIDX_DATA) begin
              d.bidx = q.bidx + 2'h1;
            end
          end
        end
      end
      S_TX: begin
        if (fall) begin
          d.sh = {q.sh[6:0], 1'b1};
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == `TSI_TX_LAST) begin
            d.st = S_MACK;
          end
        end
      end
      S_MACK: begin
        if (rise) begin
          d.nack = q.sda_s2;
        end else if (fall) begin
          if (q.nack) begin
            d.st = S_WAIT;
          end else begin
            d.st = S_TX;
            d.cnt = 4'h0;
            nt = q.alt ? !q.turn : q.turn;
            d.turn = nt;
            ld_byte = q.cmd_seen ? reply_byte : sensor_state_byte;
            sensor_state_byte_ld = nt && !q.cmd_seen;
            d.sh = nt ? ld_byte : `TSI_IDLE_BYTE;
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase

    if (stop_det) begin
      d.st = S_IDLE;
      d.cmd_seen = 1'b0;
    end else if (start_det) begin
      d.st = S_RX;
      d.cnt = 4'h0;
      d.bidx = 2'h0;
    end

    // Apart from acknowledging, a device that is not transmitting its own turn only ever releases the line.
    d.oe_n = !((d.st == S_ACK && d.ack) || (d.st == S_TX && d.turn && !d.sh[7]));
    d.sensor_state_byte_rd = sensor_state_byte_ld;

    // A new event in the clearing cycle keeps the interrupt pending.
    d.pend = own_int_event || (q.pend && !(clear_int_cmd || sensor_state_byte_ld));
    d.int_n = !(q.pend || !q.ii_s2);

    // Sample clock: the secondary clears its divider to zero and follows the input pin.
    if (secondary_mode) begin
      d.div = 16'h0000;
      d.ck_int = 1'b0;
      d.tick = !q.ck_s2 && q.ck_s3;
    end else if (q.div == 16'(SAMPLE_DIV - 1)) begin
      d.div = 16'h0000;
      d.ck_int = !q.ck_int;
      d.tick = !q.ck_int;
    end else begin
      d.div = q.div + 16'h0001;
    end
    d.ck_pin = d.ck_int && primary_mode;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // The serial port runs from the main supply and never looks at the regulated reset.
  tsi_startup u_startup (
    .core_clk(core_clk),
    .resetn(resetn),
    .chan_rst_n(q.por_n),
    .chan_enable(chan_enable),
    .near_target(near_target),
    .fine_done(fine_done),
    .chan(chan)
  );

  assign sda_out = q.sda_o;
  assign sda_oe_n = q.oe_n;
  assign clk_out = q.ck_pin;
  assign sample_tick = q.tick;
  assign int_out_n = q.int_n;
  assign regulator_off_bit = q.reg_off;
  assign intreg_por_n = q.por_n;
  assign rx_byte = q.rx_byte;
  assign rx_cmd_valid = q.cmd_vld;
  assign rx_data_valid = q.dat_vld;
  assign sensor_read = q.sensor_state_byte_rd;

  chk_reg_off_reset: assert property (
    !$past(resetn) |-> !regulator_off_bit)
    else $error("regulator off bit not cleared by reset");

  chk_por_hold: assert property (
    !q.sup_s1 && !q.sup_s2 |=> !intreg_por_n [*2])
    else $error("regulated reset released without supply");

  chk_open_drain: assert property (
    sda_out == 1'b0)
    else $error("data line driven high");

  chk_tx_stable: assert property (
    (q.st == S_TX && $past(q.st) == S_TX && q.scl_s2 && $past(q.scl_s2))
    |-> $stable(sda_oe_n))
    else $error("data drive changed while clock high");

  chk_start_restart: assert property (
    start_det && !stop_det |=> (q.st == S_RX && q.cnt == 4'h0 && q.bidx == 2'h0))
    else $error("start did not restart the byte engine");

  chk_stop_idle: assert property (
    stop_det |=> (q.st == S_IDLE && sda_oe_n && !q.cmd_seen))
    else $error("stop did not release and idle");

  chk_ack_hold: assert property (
    (q.st == S_ACK && q.ack) |-> !sda_oe_n)
    else $error("acknowledge not held low");

  chk_addr_match: assert property (
    (q.st == S_RX && q.bidx == 2'h0 && fall && q.cnt == `TSI_BIT_LAST
     && own_match && !start_det && !stop_det) |=> (q.st == S_ACK && q.ack [*1]))
    else $error("matching address not acknowledged");

  chk_foreign_addr: assert property (
    (q.st == S_RX && q.bidx == 2'h0 && fall && q.cnt == `TSI_BIT_LAST
     && !own_match && !alt_match && !start_det && !stop_det) |=> ##[0:2] sda_oe_n)
    else $error("foreign address acknowledged");

  chk_master_nack: assert property (
    q.st == S_MACK |-> sda_oe_n)
    else $error("data line held during master acknowledge");

  chk_int_chain: assert property (
    !q.ii_s2 |=> !int_out_n)
    else $error("cascaded interrupt not passed on");

  chk_sec_sample: assert property (
    (secondary_mode && $past(secondary_mode) && fall == 1'b0 && !q.ck_s2 && q.ck_s3)
    |=> sample_tick)
    else $error("secondary did not sample on falling input clock");
endmodule
`default_nettype wire

// file: tsi_bus_master.sv
// Bus master model that drives the serial clock and its own open-drain data enable.
`timescale 1ns/100ps
`default_nettype none
module tsi_bus_master (
  input wire logic sda,
  output logic scl,
  output logic sda_oe_n
);
  initial begin
    scl = 1'h1;
    sda_oe_n = 1'h1;
  end

  // Data moves only while the clock is low, so it never looks like a condition.
  task automatic xbit(input logic b, output logic r);
    sda_oe_n = b;
    #40 scl = 1'h1;
    #40 r = sda;
    #40 scl = 1'h0;
    #40;
  endtask

  // Also serves as repeated start, so the line is released before the clock rises.
  task automatic start();
    sda_oe_n = 1'h1;
    #40 scl = 1'h1;
    #80 sda_oe_n = 1'h0;
    #80 scl = 1'h0;
    #40;
  endtask

  task automatic stop();
    sda_oe_n = 1'h0;
    #40 scl = 1'h1;
    #80 sda_oe_n = 1'h1;
    #80;
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(v[i], r);
    end
    xbit(1'h1, ack);
  endtask

  task automatic rbyte(input logic ack_n, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'h1, v[i]);
    end
    xbit(ack_n, r);
  endtask
endmodule
`default_nettype wire

// file: test_tsi_core.sv
// Self-checking bench for the sensor serial slave, cascade and start-up logic.
`timescale 1ns/100ps
`default_nettype none
module test_tsi_core;
  import tsi_pkg::*;
  logic core_clk = 1'h0, resetn = 1'h0, clk_in = 1'h0, int_in_n = 1'h1;
  logic primary_mode = 1'h0, secondary_mode = 1'h0, cascade_en = 1'h0;
  logic regulator_off_wr = 1'h0, regulator_off_wdata = 1'h0, intreg_supply_ok = 1'h0;
  logic own_int_event = 1'h0, clear_int_cmd = 1'h0, address_select_pin = 1'h1;
  logic [7:0] sensor_state_byte = 8'h00, reply_byte = 8'h69, chan_enable = 8'hFF;
  logic [7:0] near_target = 8'h00, fine_done = 8'h00, rx_byte, d;
  logic scl_in, sda_out, sda_oe_n, m_oe_n, clk_out, sample_tick, int_out_n, a;
  logic rx_cmd_valid, rx_data_valid, sensor_read, regulator_off_bit, intreg_por_n;
  tsi_chan_s chan;
  int n_errors = 0, n_compared = 0, n_cmd = 0, n_dat = 0, n_rd = 0;
  int n_tick = 0, n_rise = 0, n_cyc = 0;
  // Pull-up on the data line: high unless some party pulls it low.
  wire sda_in = (sda_oe_n | sda_out) & m_oe_n;

  tsi_core #(.SAMPLE_DIV(2)) u_dut (.core_clk, .resetn, .scl_in, .sda_in, .sda_out,
    .sda_oe_n, .address_select_pin, .clk_in, .clk_out, .sample_tick, .int_in_n,
    .int_out_n, .primary_mode, .secondary_mode, .cascade_en, .regulator_off_wr,
    .regulator_off_wdata, .regulator_off_bit, .intreg_supply_ok, .intreg_por_n,
    .own_int_event, .clear_int_cmd, .sensor_state_byte, .reply_byte, .rx_byte,
    .rx_cmd_valid, .rx_data_valid, .sensor_read, .chan_enable, .near_target,
    .fine_done, .chan);
  tsi_bus_master u_mst (.sda(sda_in), .scl(scl_in), .sda_oe_n(m_oe_n));

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    n_cmd += (rx_cmd_valid === 1'h1);
    n_dat += (rx_data_valid === 1'h1);
    n_rd += (sensor_read === 1'h1);
    n_tick += (sample_tick === 1'h1);
    n_rise += $rose(clk_out);
    n_cyc++;
    if (n_cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d, mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic t_reset();
    chk(sda_oe_n, 1, "idle data");
    chk(sda_out, 0, "data value");
    chk(regulator_off_bit, 0, "reg off");
    chk(chan, 24'hFF0000, "chan");
    chk(intreg_por_n, 0, "por");
    intreg_supply_ok = 1'h1;
    cyc(2);
    chk(intreg_por_n, 0, "por early");
    cyc(2);
    chk(intreg_por_n, 1, "por");
    regulator_off_wr = 1'h1;
    regulator_off_wdata = 1'h1;
    cyc(1);
    regulator_off_wr = 1'h0;
    cyc(1);
    chk(regulator_off_bit, 1, "reg off");
    // A second reset in mid-run must clear the regulator-off bit again.
    resetn = 1'h0;
    cyc(5);
    resetn = 1'h1;
    cyc(4);
    chk(regulator_off_bit, 0, "reg off reset");
    chk(intreg_por_n, 1, "por after reset");
  endtask

  // Channels 0 and 1 advance on their own while the rest stay in fast start.
  task automatic t_start();
    near_target = 8'h01;
    cyc(6);
    chk(chan, 24'hFE0100, "ch fine");
    near_target = 8'h03;
    fine_done = 8'h01;
    cyc(6);
    chk(chan, 24'hFC0201, "ch run");
  endtask

  task automatic t_int();
    own_int_event = 1'h1;
    cyc(1);
    own_int_event = 1'h0;
    cyc(2);
    chk(int_out_n, 0, "int set");
    clear_int_cmd = 1'h1;
    cyc(1);
    clear_int_cmd = 1'h0;
    cyc(2);
    chk(int_out_n, 1, "int clr");
    int_in_n = 1'h0;
    cyc(4);
    chk(int_out_n, 0, "int chain");
    int_in_n = 1'h1;
    cyc(4);
    chk(int_out_n, 1, "int chain");
    own_int_event = 1'h1;
    clear_int_cmd = 1'h1;
    cyc(1);
    own_int_event = 1'h0;
    clear_int_cmd = 1'h0;
    cyc(2);
    chk(int_out_n, 0, "set wins");
  endtask

  // Regulated domain is switched off first; the bus must still answer.
  task automatic t_write();
    intreg_supply_ok = 1'h0;
    cyc(4);
    chk(intreg_por_n, 0, "por off");
    u_mst.start();
    u_mst.wbyte(8'h42, a);
    chk(a, 0, "ack adr");
    u_mst.wbyte(8'h5A, a);
    chk({a, rx_byte}, 9'h05A, "cmd");
    u_mst.wbyte(8'hA5, a);
    chk({a, rx_byte}, 9'h0A5, "data");
    u_mst.wbyte(8'h3C, a);
    chk({a, rx_byte}, 9'h03C, "data2");
    u_mst.stop();
    chk({n_cmd[7:0], n_dat[7:0]}, 16'h0102, "pulses");
  endtask

  task automatic t_nack();
    logic [7:0] adr[3] = '{8'h40, 8'h52, 8'hC3};
    for (int i = 0; i < 3; i++) begin
      u_mst.start();
      u_mst.wbyte(adr[i], a);
      chk(a, 1, "foreign adr");
      u_mst.stop();
    end
  endtask

  task automatic t_read();
    own_int_event = 1'h1;
    cyc(1);
    own_int_event = 1'h0;
    sensor_state_byte = 8'hC3;
    u_mst.start();
    u_mst.wbyte(8'h43, a);
    chk(a, 0, "ack rd");
    fork
      u_mst.rbyte(1'h0, d);
      #400 sensor_state_byte = 8'h3C;
    join
    chk(d, 8'hC3, "sens1");
    u_mst.rbyte(1'h1, d);
    chk(d, 8'h3C, "sens2");
    chk(sda_in, 1, "released");
    u_mst.stop();
    chk({n_rd[7:0], int_out_n}, 9'h005, "read clr");
  endtask

  task automatic t_restart();
    u_mst.start();
    u_mst.wbyte(8'h42, a);
    u_mst.wbyte(8'h11, a);
    u_mst.start();
    u_mst.wbyte(8'h43, a);
    chk(a, 0, "restart ack");
    u_mst.rbyte(1'h1, d);
    chk(d, 8'h69, "reply");
    u_mst.stop();
  endtask

  task automatic t_clk();
    primary_mode = 1'h1;
    cyc(4);
    {n_tick, n_rise} = '0;
    cyc(80);
    chk(n_rise inside {[19:21]} && n_tick - n_rise inside {[-1:1]}, 1, "primary");
    primary_mode = 1'h0;
    secondary_mode = 1'h1;
    cyc(8);
    {n_tick, n_rise} = '0;
    // Seven falls and eight rises, so ticks on the wrong edge show as a count of 8.
    repeat (7) begin
      clk_in = 1'h1;
      #80 clk_in = 1'h0;
      #80;
    end
    clk_in = 1'h1;
    cyc(20);
    chk({n_tick[7:0], n_rise[7:0]}, 16'h0700, "secondary");
    clk_in = 1'h0;
  endtask

  task automatic t_cascade();
    cascade_en = 1'h1;
    sensor_state_byte = 8'h5A;
    u_mst.start();
    u_mst.wbyte(8'h41, a);
    chk(a, 1, "no ack");
    u_mst.rbyte(1'h0, d);
    chk(d, 8'hFF, "primary turn");
    u_mst.rbyte(1'h0, d);
    chk(d, 8'h5A, "own turn");
    u_mst.rbyte(1'h1, d);
    chk(d, 8'hFF, "primary turn");
    u_mst.stop();
    // The same alternating read, now seen from the primary side.
    secondary_mode = 1'h0;
    primary_mode = 1'h1;
    address_select_pin = 1'h0;
    cyc(4);
    u_mst.start();
    u_mst.wbyte(8'h41, a);
    chk(a, 0, "primary ack");
    u_mst.rbyte(1'h0, d);
    chk(d, 8'h5A, "primary own");
    u_mst.rbyte(1'h0, d);
    chk(d, 8'hFF, "secondary turn");
    u_mst.rbyte(1'h1, d);
    chk(d, 8'h5A, "primary again");
    u_mst.stop();
  endtask

  initial begin
    cyc(5);
    resetn = 1'h1;
    cyc(4);
    t_reset();
    t_start();
    t_int();
    t_write();
    t_nack();
    t_read();
    t_restart();
    t_clk();
    t_cascade();
    conclude();
  end
endmodule
`default_nettype wire
